// ===== src/tcrd_consts.svh
`ifndef TCRD_CONSTS_SVH
`define TCRD_CONSTS_SVH
`define TCRD_CLK_HZ        32'h0098_9680
`define TCRD_TICK_SEC      32'h0000_0001
`define TCRD_TICK_CYCLES   (`TCRD_CLK_HZ * `TCRD_TICK_SEC)
`define TCRD_VAL_MAX       32'h0001_869F
`define TCRD_VAL_MIN       (-32'sh0001_869F)
`define TCRD_HIGH_RST      32'h0000_2710
`define TCRD_LOW_RST       32'h0000_0000
`define TCRD_TIME_MAX      16'h03E7
`define TCRD_CYC_CTL_RST   16'h000A
`define TCRD_CYC_PUL_RST   16'h000A
`define TCRD_ON_RST        16'h0005
`define TCRD_ADR_CTRL      8'h00
`define TCRD_ADR_HIGH      8'h04
`define TCRD_ADR_LOW       8'h08
`define TCRD_ADR_CYCLE     8'h0C
`define TCRD_ADR_ON        8'h10
`define TCRD_ADR_PROC      8'h14
`define TCRD_ADR_STAT      8'h18
`define TCRD_CTRL_MODE     0
`define TCRD_CTRL_INV      1
`define TCRD_CTRL_RST      32'h0000_0000
`define TCRD_CYCLE_RST     32'h0000_000A
`define TCRD_ON_RST32      32'h0000_0005
`endif

// ===== src/tcrd_pkg.sv
package tcrd_pkg;
	typedef enum logic [1:0] {
		TCRD_IDLE = 2'b00,
		TCRD_ON   = 2'b01,
		TCRD_OFF  = 2'b11
	} tcrd_state_t;
	typedef logic signed [31:0] tcrd_val_t;
endpackage : tcrd_pkg

// ===== src/tcrd_relay.sv
`timescale 1ns/1ps
`include "tcrd_consts.svh"
// Contract
// - on when value above both ranges
// - off when value below both ranges
// - hold decision inside dead band
// - active decision pulses by cycle/on times
// - invert: cycle on below both ranges
// - high range signed, default 100.00
// - low range signed, default 0.00
// - invert defaults disabled, reverses sense
// - cycle time 0..999 s, default 10
// - pulse mode fixed duty when input on
// - pulse mode on time per cycle
// - pulse mode off while input off
// - pulse mode invert flips input
module tcrd_relay #(
	parameter int unsigned TICK_CYCLES = `TCRD_TICK_CYCLES
) (
	input  wire logic                ref_clk_i,
	input  wire logic                sys_rst_i,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire tcrd_pkg::tcrd_val_t process_value_i,
	input  wire logic                digital_in_i,
	output logic                     relay_o
);
	import tcrd_pkg::*;

	logic [31:0] ctrl_reg, ctrl_next;
	tcrd_val_t   high_reg, high_next;
	tcrd_val_t   low_reg, low_next;
	logic [15:0] cycle_reg, cycle_next;
	logic [15:0] on_reg, on_next;
	logic [31:0] dat_reg, dat_next;
	logic        ack_reg, ack_next;
	tcrd_val_t   proc_s1_reg, proc_s2_reg;
	logic        din_s1_reg, din_s2_reg;
	logic [31:0] div_reg, div_next;
	logic        tick_reg, tick_next;
	logic [15:0] sec_reg, sec_next;
	logic        dec_reg, dec_next;
	logic        relay_reg, relay_next;
	tcrd_state_t st_reg, st_next;
	logic        req;
	logic [31:0] wmask;
	logic [31:0] wval;

	// two flops on pins; first stage feeds only the second
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			proc_s1_reg <= '0;
			proc_s2_reg <= '0;
			din_s1_reg <= 1'b0;
			din_s2_reg <= 1'b0;
		end else begin
			proc_s1_reg <= process_value_i;
			proc_s2_reg <= proc_s1_reg;
			din_s1_reg <= digital_in_i;
			din_s2_reg <= din_s1_reg;
		end
	end

	// register bus, answers one cycle after request
	always_comb begin
		ctrl_next  = ctrl_reg;
		high_next  = high_reg;
		low_next   = low_reg;
		cycle_next = cycle_reg;
		on_next    = on_reg;
		dat_next   = dat_reg;
		ack_next   = 1'b0;
		wmask      = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		wval       = 32'h0000_0000;
		if (wb_cyc_i && wb_stb_i && !ack_reg) begin
			ack_next = 1'b1;
			dat_next = 32'h0000_0000;
			if (wb_adr_i == `TCRD_ADR_CTRL) begin
				dat_next = ctrl_reg;
				wval = (ctrl_reg & ~wmask) | (wb_dat_i & wmask);
				if (wb_we_i) ctrl_next = wval & 32'h0000_0003;
			end else if (wb_adr_i == `TCRD_ADR_HIGH) begin
				dat_next = high_reg;
				wval = (high_reg & ~wmask) | (wb_dat_i & wmask);
				// out-of-range writes are ignored
				if (wb_we_i && $signed(wval) <= $signed(`TCRD_VAL_MAX)
					&& $signed(wval) >= $signed(`TCRD_VAL_MIN)) high_next = wval;
			end else if (wb_adr_i == `TCRD_ADR_LOW) begin
				dat_next = low_reg;
				wval = (low_reg & ~wmask) | (wb_dat_i & wmask);
				if (wb_we_i && $signed(wval) <= $signed(`TCRD_VAL_MAX)
					&& $signed(wval) >= $signed(`TCRD_VAL_MIN)) low_next = wval;
			end else if (wb_adr_i == `TCRD_ADR_CYCLE) begin
				dat_next = {16'h0000, cycle_reg};
				wval = ({16'h0000, cycle_reg} & ~wmask) | (wb_dat_i & wmask);
				if (wb_we_i && wval <= {16'h0000, `TCRD_TIME_MAX}) cycle_next = wval[15:0];
			end else if (wb_adr_i == `TCRD_ADR_ON) begin
				dat_next = {16'h0000, on_reg};
				wval = ({16'h0000, on_reg} & ~wmask) | (wb_dat_i & wmask);
				if (wb_we_i && wval <= {16'h0000, `TCRD_TIME_MAX}) on_next = wval[15:0];
			end else if (wb_adr_i == `TCRD_ADR_PROC) begin
				dat_next = proc_s2_reg;
			end else if (wb_adr_i == `TCRD_ADR_STAT) begin
				dat_next = {29'h0, dec_reg, din_s2_reg, relay_reg};
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			ctrl_reg  <= `TCRD_CTRL_RST;
			high_reg  <= `TCRD_HIGH_RST;
			low_reg   <= `TCRD_LOW_RST;
			cycle_reg <= `TCRD_CYC_CTL_RST;
			on_reg    <= `TCRD_ON_RST;
			dat_reg   <= 32'h0000_0000;
			ack_reg   <= 1'b0;
		end else begin
			ctrl_reg  <= ctrl_next;
			high_reg  <= high_next;
			low_reg   <= low_next;
			cycle_reg <= cycle_next;
			on_reg    <= on_next;
			dat_reg   <= dat_next;
			ack_reg   <= ack_next;
		end
	end

	// decision and timing
	always_comb begin
		div_next   = div_reg + 32'h0000_0001;
		tick_next  = 1'b0;
		dec_next   = dec_reg;
		sec_next   = sec_reg;
		st_next    = st_reg;
		relay_next = relay_reg;
		if (div_reg >= TICK_CYCLES - 1) begin
			div_next  = 32'h0000_0000;
			tick_next = 1'b1;
		end
		if (ctrl_reg[`TCRD_CTRL_MODE]) begin
			dec_next = din_s2_reg ^ ctrl_reg[`TCRD_CTRL_INV];
		end else if (!ctrl_reg[`TCRD_CTRL_INV]) begin
			if (proc_s2_reg > high_reg && proc_s2_reg > low_reg) dec_next = 1'b1;
			else if (proc_s2_reg < high_reg && proc_s2_reg < low_reg) dec_next = 1'b0;
			// otherwise hold: dead band
		end else begin
			if (proc_s2_reg < high_reg && proc_s2_reg < low_reg) dec_next = 1'b1;
			else if (proc_s2_reg > high_reg && proc_s2_reg > low_reg) dec_next = 1'b0;
		end
		req = 1'b0;
		case (st_reg)
			TCRD_IDLE: begin
				relay_next = 1'b0;
				sec_next   = 16'h0000;
				if (dec_reg) begin
					st_next    = TCRD_ON;
					relay_next = 1'b1;
				end
			end
			TCRD_ON: begin
				relay_next = 1'b1;
				if (!dec_reg) begin
					st_next    = TCRD_IDLE;
					relay_next = 1'b0;
				end else if (cycle_reg == 16'h0000 || on_reg >= cycle_reg) begin
					sec_next = 16'h0000;
				end else if (tick_reg) begin
					sec_next = sec_reg + 16'h0001;
					if (sec_reg + 16'h0001 >= on_reg) begin
						st_next    = TCRD_OFF;
						relay_next = 1'b0;
					end
				end
			end
			TCRD_OFF: begin
				relay_next = 1'b0;
				if (!dec_reg) begin
					st_next = TCRD_IDLE;
				end else if (cycle_reg == 16'h0000 || on_reg >= cycle_reg) begin
					st_next    = TCRD_ON;
					relay_next = 1'b1;
					sec_next   = 16'h0000;
				end else if (tick_reg) begin
					sec_next = sec_reg + 16'h0001;
					if (sec_reg + 16'h0001 >= cycle_reg) begin
						req        = 1'b1;
						st_next    = TCRD_ON;
						relay_next = (on_reg != 16'h0000);
						sec_next   = 16'h0000;
					end
				end
			end
			default: begin
				st_next    = TCRD_IDLE;
				relay_next = 1'b0;
			end
		endcase
		// zero on time keeps the coil off unless cycle time is also zero
		if (st_next == TCRD_ON && on_reg == 16'h0000 && cycle_reg != 16'h0000) begin
			relay_next = 1'b0;
			if (req) st_next = TCRD_OFF;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			div_reg   <= 32'h0000_0000;
			tick_reg  <= 1'b0;
			sec_reg   <= 16'h0000;
			dec_reg   <= 1'b0;
			relay_reg <= 1'b0;
			st_reg    <= TCRD_IDLE;
		end else begin
			div_reg   <= div_next;
			tick_reg  <= tick_next;
			sec_reg   <= sec_next;
			dec_reg   <= dec_next;
			relay_reg <= relay_next;
			st_reg    <= st_next;
		end
	end

	assign wb_dat_o = dat_reg;
	assign wb_ack_o = ack_reg;
	assign relay_o  = relay_reg;
endmodule : tcrd_relay

// ===== bench/tcrd_src_model.sv
`timescale 1ns/1ps
module tcrd_src_model (
	input  wire logic                clk_i,
	input  wire tcrd_pkg::tcrd_val_t proc_set_i,
	input  wire logic                din_set_i,
	input  wire logic                relay_i,
	output tcrd_pkg::tcrd_val_t      process_value_o = 32'sh0000_0000,
	output logic                     digital_o = 1'b0,
	output int unsigned              coil_cnt_o
);
	import tcrd_pkg::*;
	// sources move only on the edge; coil counts energised cycles
	always @(posedge clk_i) begin
		process_value_o <= proc_set_i;
		digital_o <= din_set_i;
		coil_cnt_o <= coil_cnt_o + 32'(relay_i);
	end
endmodule : tcrd_src_model

// ===== bench/tcrd_relay_props.sv
`timescale 1ns/1ps
`include "tcrd_consts.svh"
module tcrd_props #(
	parameter int unsigned TICK_CYCLES = 10
) (
	input wire logic                ref_clk_i,
	input wire logic                sys_rst_i,
	input wire logic                wb_cyc_i,
	input wire logic                wb_stb_i,
	input wire logic                wb_we_i,
	input wire logic [7:0]          wb_adr_i,
	input wire logic [31:0]         wb_dat_i,
	input wire logic                wb_ack_o,
	input wire tcrd_pkg::tcrd_val_t process_value_i,
	input wire logic                digital_in_i,
	input wire logic                relay_o
);
	import tcrd_pkg::*;
	logic [1:0] ctl_reg;
	logic [1:0] ctl_next;
	// snooped mode; lags one edge, so windows below are long
	always_comb begin
		ctl_next = ctl_reg;
		if (sys_rst_i) ctl_next = 2'h0;
		else if (wb_ack_o && wb_we_i && wb_adr_i == `TCRD_ADR_CTRL) ctl_next = wb_dat_i[1:0];
	end
	always_ff @(posedge ref_clk_i) ctl_reg <= ctl_next;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_ack_taken: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
	a_reset_off: assert property (disable iff (1'b0) sys_rst_i |=> !relay_o && !wb_ack_o)
		else $error("relay on after reset");
	a_pulse_idle: assert property ((ctl_reg == 2'h1 && !digital_in_i)[*8] |-> !relay_o)
		else $error("relay on with input off");
	a_pulse_invert: assert property ((ctl_reg == 2'h3 && digital_in_i)[*8] |-> !relay_o)
		else $error("inverted input not applied");
	a_below_off: assert property ((ctl_reg == 2'h0 && process_value_i < `TCRD_VAL_MIN)[*8]
		|-> !relay_o) else $error("relay on below ranges");
	a_invert_off: assert property ((ctl_reg == 2'h2 && process_value_i > 32'sh0001_869F)[*8]
		|-> !relay_o) else $error("inverted relay on above ranges");
	c_pulse: cover property (ctl_reg == 2'h1 && $rose(relay_o));
	c_ctrl: cover property (ctl_reg == 2'h0 && $rose(relay_o));
	c_write: cover property (wb_ack_o && wb_we_i);
endmodule : tcrd_props
bind tcrd_relay tcrd_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.ref_clk_i(ref_clk_i),
	.sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
	.process_value_i(process_value_i), .digital_in_i(digital_in_i), .relay_o(relay_o));

// ===== bench/tb.sv
`timescale 1ns/1ps
`include "tcrd_consts.svh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin failures++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module tb;
	logic                clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, din_s = 1'b0;
	logic                ack, relay, din;
	logic [7:0]          adr = 8'h00;
	logic [31:0]         wdat = 32'h0000_0000, rdat, q;
	tcrd_pkg::tcrd_val_t proc_set = 32'sh0000_0000, proc_val;
	int unsigned         cnt, c0, k;
	int                  failures = 0, checked = 0, seed = 22;
	initial forever #50 clk = ~clk;
	// short tick: one second is ten clocks
	tcrd_relay #(.TICK_CYCLES(10)) dut (.ref_clk_i(clk), .sys_rst_i(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .process_value_i(proc_val), .digital_in_i(din),
		.relay_o(relay));
	tcrd_src_model src (.clk_i(clk), .proc_set_i(proc_set), .din_set_i(din_s), .relay_i(relay),
		.process_value_o(proc_val), .digital_o(din), .coil_cnt_o(cnt));
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
		n = 0;
		do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0; stb <= 1'b0;
		if (n >= 50) begin
			failures++;
			end_of_test;
		end
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		wb(1'b0, a, 32'h0000_0000);
		`CHK(n, e, q)
	endtask : rd
	function automatic int unsigned on_pct(input int unsigned o, input int unsigned c);
		return (c == 0 || o >= c) ? 100 : o * 100 / c;
	endfunction : on_pct
	// one full cycle window, so phase does not matter
	task automatic meas(input int unsigned e, input string n);
		repeat (250) @(posedge clk);
		c0 = cnt;
		repeat (100) @(posedge clk);
		`CHK(n, e, cnt - c0)
		$display("test %s done", n);
	endtask : meas
	task automatic end_of_test;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		end_of_test;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		`CHK("relay", 1'b0, relay)
		rd(`TCRD_ADR_CTRL, `TCRD_CTRL_RST, "ctrl");
		rd(`TCRD_ADR_HIGH, `TCRD_HIGH_RST, "high");
		rd(`TCRD_ADR_LOW, `TCRD_LOW_RST, "low");
		rd(`TCRD_ADR_CYCLE, `TCRD_CYCLE_RST, "cycle");
		rd(`TCRD_ADR_ON, `TCRD_ON_RST32, "on");
		rd(8'h1C, 32'h0000_0000, "unmapped");
		wb(1'b1, `TCRD_ADR_HIGH, 32'h0001_86A0);
		rd(`TCRD_ADR_HIGH, `TCRD_HIGH_RST, "high_big");
		wb(1'b1, `TCRD_ADR_CYCLE, 32'h0000_03E8);
		rd(`TCRD_ADR_CYCLE, `TCRD_CYCLE_RST, "cycle_big");
		k = {$random(seed)} % 2000;
		wb(1'b1, `TCRD_ADR_LOW, k);
		wb(1'b1, `TCRD_ADR_HIGH, 32'h0000_0BB8);
		rd(`TCRD_ADR_LOW, k, "low_rand");
		proc_set <= 32'sh0000_1388;
		meas(on_pct(5, 10), "above");
		rd(`TCRD_ADR_PROC, 32'h0000_1388, "proc_rd");
		proc_set <= 32'sh0000_09C4;
		meas(on_pct(5, 10), "band_on");
		proc_set <= -32'sh0003_0D40;
		meas(0, "below");
		proc_set <= 32'sh0000_09C4;
		meas(0, "band_off");
		wb(1'b1, `TCRD_ADR_CTRL, 32'h0000_0002);
		proc_set <= -32'sh0003_0D40;
		meas(on_pct(5, 10), "inv_below");
		proc_set <= 32'sh0003_0D40;
		meas(0, "inv_above");
		wb(1'b1, `TCRD_ADR_CTRL, 32'h0000_0001);
		din_s <= 1'b1;
		meas(on_pct(5, 10), "pulse_on");
		din_s <= 1'b0;
		meas(0, "pulse_off");
		wb(1'b1, `TCRD_ADR_CTRL, 32'h0000_0003);
		meas(on_pct(5, 10), "pulse_inv");
		din_s <= 1'b1;
		meas(0, "pulse_inv_on");
		wb(1'b1, `TCRD_ADR_CTRL, 32'h0000_0001);
		for (int i = 0; i < 3; i++) begin
			k = {$random(seed)} % 13;
			wb(1'b1, `TCRD_ADR_ON, k);
			meas(on_pct(k, 10), "on_rand");
		end
		wb(1'b1, `TCRD_ADR_CYCLE, 32'h0000_0000);
		meas(100, "cycle_zero");
		rd(`TCRD_ADR_STAT, 32'h0000_0007, "stat");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK("relay_rst", 1'b0, relay)
		rst <= 1'b0;
		rd(`TCRD_ADR_CYCLE, `TCRD_CYCLE_RST, "cycle_rst");
		end_of_test;
	end
endmodule : tb
